// ===== design/smio_scan_matrix_io.v
// Purpose: Operation panel I/O unit: key matrix scan, lamp matrix
//          multiplex, filtered plain inputs, plain outputs, station
//          switches and per-station alarm lamps, over APB.
// Assumes: One 40 MHz clock; synchronous active-high reset.
// Notes:   Pin inputs pass two flops before use.
//
// Functional notes
// R1: Key input is eight commons by eight data.
// R2: Key data captured only while common is low.
// R3: All eight key commons cycle in 11.68 ms.
// R4: Panel holds keys at least one ladder cycle.
// R5: Lamp lights only while its common is high.
// R6: Four lamp commons, 1.46 ms each, 5.84 ms.
// R7: Addresses in 32 point units from switches.
// R8: Installer sets three distinct stations 0 to 7.
// R9: Installer normally sets switches 0, 1, 2.
// R10: Alarm lamp per station lit on link error.
// R11: Plain inputs map to consecutive input addresses.
// R12: Machine holds plain inputs 40 ms or more.
// R13: Plain input change reflected within 16 ms.
// R14: Plain inputs filtered against short chatter.
`timescale 1ns/10ps
`include "smio_consts.vh"
module smio_scan_matrix_io #(
    parameter KEY_SLOT_CYC  = `SMIO_KEY_SLOT_CYC,
    parameter LAMP_SLOT_CYC = `SMIO_LAMP_SLOT_CYC,
    parameter FILT_CYC      = `SMIO_FILT_CYC
) (
    // Clock and reset.
    input  wire        i_sys_clk,
    input  wire        i_reset,
    // APB slave.
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    // Key matrix (active low on both sides).
    output wire [7:0]  o_key_matrix_common_lines_n,
    input  wire [7:0]  i_key_matrix_data_lines_n,
    // Lamp matrix, banks A and B.
    output wire [3:0]  o_lamp_matrix_common_a,
    output wire [3:0]  o_lamp_matrix_common_b,
    output wire [7:0]  o_lamp_matrix_data_lines_a_n,
    output wire [7:0]  o_lamp_matrix_data_lines_b_n,
    // Plain digital inputs and outputs.
    input  wire [31:0] i_plain_inputs,
    output wire [31:0] o_plain_outputs,
    // Station switches.
    input  wire [2:0]  i_first_scan_station_switch,
    input  wire [2:0]  i_second_scan_station_switch,
    input  wire [2:0]  i_plain_io_station_switch,
    // Link error levels from the link logic, one per station.
    input  wire [2:0]  i_station_link_error,
    // Alarm lamps and interrupt.
    output wire        o_first_station_alarm_led,
    output wire        o_second_station_alarm_led,
    output wire        o_third_station_alarm_led,
    output wire        o_irq
);
    localparam KW = $clog2(KEY_SLOT_CYC + 1);
    localparam LW = $clog2(LAMP_SLOT_CYC + 1);

    ////////////////////////////////////////////////////////////////////
    // Address decode used by both the write enable and the error paths.
    function addr_valid;
        input [7:0] a;
        begin
            case (a)
                `SMIO_OFS_CTRL, `SMIO_OFS_STATUS, `SMIO_OFS_MASK,
                `SMIO_OFS_KEY_LO, `SMIO_OFS_KEY_HI, `SMIO_OFS_LAMP_A,
                `SMIO_OFS_LAMP_B, `SMIO_OFS_DIN, `SMIO_OFS_DOUT,
                `SMIO_OFS_STATION, `SMIO_OFS_ALARM: addr_valid = 1'b1;
                default: addr_valid = 1'b0;
            endcase
        end
    endfunction

    // Base point address of a station: 32 points per station number.
    function [7:0] unit_base;
        input [2:0] st;
        begin
            unit_base = {st, 5'h00};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Software registers.
    reg [31:0] ctrl_q;          // Scan and lamp enables.
    reg [`SMIO_ST_BITS-1:0] status_q; // Sticky events.
    reg [`SMIO_ST_BITS-1:0] status_d; // Next sticky events.
    reg [`SMIO_ST_BITS-1:0] mask_q;   // Interrupt mask.
    reg [31:0] lamp_a_q;        // Bank A lamp image, 8 bits per common.
    reg [31:0] lamp_b_q;        // Bank B lamp image.
    reg [31:0] dout_q;          // Plain output image.
    reg [31:0] prdata_q;        // Read data.
    reg        pready_q;        // Access phase answer.
    reg        pslverr_q;       // Unmapped address flag.
    reg        irq_q;           // Interrupt level.

    ////////////////////////////////////////////////////////////////////
    // Synchronisers and scan state.
    reg [7:0]  key_meta_q;      // First flop of key data.
    reg [7:0]  key_sync_q;      // Second flop of key data.
    reg [31:0] din_meta_q;      // First flop of plain inputs.
    reg [31:0] din_sync_q;      // Second flop of plain inputs.
    reg [8:0]  sw_meta_q;       // First flop of the three switches.
    reg [8:0]  sw_sync_q;       // Second flop of the three switches.
    reg [KW-1:0] key_cnt_q;     // Cycles within a key slot.
    reg [2:0]  key_idx_q;       // Active key common.
    reg [7:0]  key_com_q;       // Key commons, active low.
    reg [63:0] key_q;           // Captured key image, 1 = pressed.
    reg        key_chg_q;       // Key image changed this cycle.
    reg [LW-1:0] lamp_cnt_q;    // Cycles within a lamp slot.
    reg [1:0]  lamp_idx_q;      // Active lamp common.
    reg [1:0]  lamp_idx_d;      // Next lamp common.
    reg [3:0]  lamp_com_a_q;    // Bank A commons, active high.
    reg [3:0]  lamp_com_b_q;    // Bank B commons, active high.
    reg [7:0]  lamp_dat_a_q;    // Bank A data, active low.
    reg [7:0]  lamp_dat_b_q;    // Bank B data, active low.
    reg [2:0]  alarm_q;         // Alarm lamps per station.
    reg        conflict_q;      // Station numbers collide.
    reg [31:0] rd_mux;          // Read mux output.

    wire [31:0] din_filt;       // Filtered plain inputs.
    wire [31:0] din_chg;        // Per-bit acceptance pulses.
    wire        key_en  = ctrl_q[`SMIO_CTRL_KEY_EN];
    wire        lamp_en = ctrl_q[`SMIO_CTRL_LAMP_EN];
    wire [2:0]  st1 = sw_sync_q[2:0];
    wire [2:0]  st2 = sw_sync_q[5:3];
    wire [2:0]  st3 = sw_sync_q[8:6];
    wire        conflict = (st1 == st2) | (st1 == st3) | (st2 == st3);
    wire        key_end  = (key_cnt_q == KEY_SLOT_CYC[KW-1:0] - 1'b1);
    wire        lamp_end = (lamp_cnt_q == LAMP_SLOT_CYC[LW-1:0] - 1'b1);
    wire        acc      = i_psel & i_penable;
    wire        wr_en    = acc & i_pwrite & pready_q &
                           addr_valid(i_paddr);

    ////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every pin input.
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            key_meta_q <= 8'hff;
            key_sync_q <= 8'hff;
            din_meta_q <= 32'h0000_0000;
            din_sync_q <= 32'h0000_0000;
            sw_meta_q  <= 9'h000;
            sw_sync_q  <= 9'h000;
        end else begin
            key_meta_q <= i_key_matrix_data_lines_n;
            key_sync_q <= key_meta_q;
            din_meta_q <= i_plain_inputs;
            din_sync_q <= din_meta_q;
            sw_meta_q  <= {i_plain_io_station_switch,
                           i_second_scan_station_switch,
                           i_first_scan_station_switch};
            sw_sync_q  <= sw_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Key scan: one common low per slot, eight slots per cycle. The
    // row is captured on the last cycle of its slot, while its common
    // is still low, so data settles for all but the last two cycles of the slot.
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            key_cnt_q <= {KW{1'b0}};
            key_idx_q <= 3'h0;
            key_com_q <= 8'hff;
            key_q     <= 64'h0;
            key_chg_q <= 1'b0;
        end else begin
            key_chg_q <= 1'b0;
            if (!key_en) begin
                // Stopped scan releases every common.
                key_cnt_q <= {KW{1'b0}};
                key_idx_q <= 3'h0;
                key_com_q <= 8'hff;
            end else if (key_com_q == 8'hff) begin
                // First slot after enabling starts with common 0.
                key_com_q <= ~(8'h01 << key_idx_q); // R1
            end else if (key_end) begin
                key_cnt_q <= {KW{1'b0}};
                key_q[key_idx_q*8 +: 8] <= ~key_sync_q; // R2 R1
                key_chg_q <= (key_q[key_idx_q*8 +: 8] != ~key_sync_q);
                key_idx_q <= key_idx_q + 3'h1; // R3
                key_com_q <= ~(8'h01 << (key_idx_q + 3'h1)); // R3
            end else begin
                key_cnt_q <= key_cnt_q + 1'b1; // R3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lamp common sequence: the next index feeds commons and data on
    // the same edge, so a lamp never sees another common's data.
    always @* begin
        lamp_idx_d = lamp_idx_q;
        if (lamp_en && lamp_end) begin
            lamp_idx_d = lamp_idx_q + 2'h1; // R6
        end else if (!lamp_en) begin
            lamp_idx_d = 2'h0;
        end
    end

    // Lamp outputs: data low lights a lamp while its common is high.
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            lamp_cnt_q   <= {LW{1'b0}};
            lamp_idx_q   <= 2'h0;
            lamp_com_a_q <= 4'h0;
            lamp_com_b_q <= 4'h0;
            lamp_dat_a_q <= 8'hff;
            lamp_dat_b_q <= 8'hff;
        end else begin
            lamp_idx_q <= lamp_idx_d;
            if (!lamp_en || lamp_end || lamp_com_a_q == 4'h0) begin
                lamp_cnt_q <= {LW{1'b0}};
            end else begin
                lamp_cnt_q <= lamp_cnt_q + 1'b1; // R6
            end
            if (lamp_en) begin
                lamp_com_a_q <= 4'h1 << lamp_idx_d; // R6
                lamp_com_b_q <= 4'h1 << lamp_idx_d; // R6
                lamp_dat_a_q <= ~lamp_a_q[lamp_idx_d*8 +: 8]; // R5
                lamp_dat_b_q <= ~lamp_b_q[lamp_idx_d*8 +: 8]; // R5
            end else begin
                // Disabled: commons low and data high, all dark.
                lamp_com_a_q <= 4'h0;
                lamp_com_b_q <= 4'h0;
                lamp_dat_a_q <= 8'hff;
                lamp_dat_b_q <= 8'hff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One chatter filter per plain input.
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_filt
            smio_input_filter #(
                .FILT_CYC (FILT_CYC)
            ) u_filt (
                .i_sys_clk (i_sys_clk),
                .i_reset   (i_reset),
                .i_level   (din_sync_q[g]),
                .o_level   (din_filt[g]),
                .o_change  (din_chg[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Alarm lamps follow each station's link error level, and the
    // station collision flag starts set so reset fakes no rise.
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            alarm_q    <= 3'h0;
            conflict_q <= 1'b1;
        end else begin
            alarm_q    <= i_station_link_error; // R10
            conflict_q <= conflict;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky status: a new event in the clearing cycle stays set.
    always @* begin
        status_d = status_q;
        if (wr_en && i_paddr == `SMIO_OFS_STATUS) begin
            status_d = status_q & ~i_pwdata[`SMIO_ST_BITS-1:0];
        end
        if (key_chg_q) begin
            status_d[`SMIO_ST_KEY_CHG] = 1'b1;
        end
        if (|din_chg) begin
            status_d[`SMIO_ST_DIN_CHG] = 1'b1; // R13
        end
        if (|(i_station_link_error & ~alarm_q)) begin
            status_d[`SMIO_ST_LINK_ERR] = 1'b1; // R10
        end
        if (conflict && !conflict_q) begin
            status_d[`SMIO_ST_CONFLICT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux over the register map.
    always @* begin
        rd_mux = 32'h0000_0000;
        case (i_paddr)
            `SMIO_OFS_CTRL:    rd_mux = ctrl_q;
            `SMIO_OFS_STATUS:  rd_mux[`SMIO_ST_BITS-1:0] = status_q;
            `SMIO_OFS_MASK:    rd_mux[`SMIO_ST_BITS-1:0] = mask_q;
            `SMIO_OFS_KEY_LO:  rd_mux = key_q[31:0];
            `SMIO_OFS_KEY_HI:  rd_mux = key_q[63:32];
            `SMIO_OFS_LAMP_A:  rd_mux = lamp_a_q;
            `SMIO_OFS_LAMP_B:  rd_mux = lamp_b_q;
            `SMIO_OFS_DIN:     rd_mux = din_filt; // R11
            `SMIO_OFS_DOUT:    rd_mux = dout_q;
            `SMIO_OFS_STATION: begin
                // Switches, then first and last plain input address.
                rd_mux[8:0]   = sw_sync_q;
                rd_mux[9]     = conflict_q;
                rd_mux[23:16] = unit_base(st3); // R7 R11
                rd_mux[31:24] = unit_base(st3 + 3'h1) -
                                8'h01; // R7 R11
            end
            `SMIO_OFS_ALARM:   rd_mux[2:0] = alarm_q;
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: one wait state; writes land at the pready edge.
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            ctrl_q    <= `SMIO_CTRL_RESET;
            status_q  <= {`SMIO_ST_BITS{1'b0}};
            mask_q    <= {`SMIO_ST_BITS{1'b0}};
            lamp_a_q  <= 32'h0000_0000;
            lamp_b_q  <= 32'h0000_0000;
            dout_q    <= 32'h0000_0000;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q    <= |(status_q & mask_q);
            pready_q <= acc & ~pready_q;
            if (acc && !pready_q) begin
                // Answer prepared during the first access cycle.
                prdata_q  <= i_pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_q <= ~addr_valid(i_paddr);
            end else begin
                pslverr_q <= 1'b0;
            end
            if (wr_en) begin
                case (i_paddr)
                    `SMIO_OFS_CTRL:   ctrl_q <= i_pwdata & 32'h0000_0003;
                    `SMIO_OFS_MASK:
                        mask_q <= i_pwdata[`SMIO_ST_BITS-1:0];
                    `SMIO_OFS_LAMP_A: lamp_a_q <= i_pwdata;
                    `SMIO_OFS_LAMP_B: lamp_b_q <= i_pwdata;
                    `SMIO_OFS_DOUT:   dout_q <= i_pwdata;
                    default:          ctrl_q <= ctrl_q;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output wiring, all from flops.
    assign o_prdata   = prdata_q;
    assign o_pready   = pready_q;
    assign o_pslverr  = pslverr_q;
    assign o_key_matrix_common_lines_n  = key_com_q;
    assign o_lamp_matrix_common_a       = lamp_com_a_q;
    assign o_lamp_matrix_common_b       = lamp_com_b_q;
    assign o_lamp_matrix_data_lines_a_n = lamp_dat_a_q;
    assign o_lamp_matrix_data_lines_b_n = lamp_dat_b_q;
    assign o_plain_outputs  = dout_q;
    assign o_first_station_alarm_led  = alarm_q[0];
    assign o_second_station_alarm_led = alarm_q[1];
    assign o_third_station_alarm_led  = alarm_q[2];
    assign o_irq = irq_q;
endmodule

// ===== design/smio_consts.vh
// Purpose: Shared constants for the scan matrix I/O unit.
// Assumes: 40 MHz system clock, APB register access, byte offsets.
// Notes:   Holds definitions only; included by bare name.
`ifndef SMIO_CONSTS_VH
`define SMIO_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// Clock and timing (times in ns, counts derived from them).
`define SMIO_CLK_PERIOD_NS    25
`define SMIO_KEY_COMMONS      8
`define SMIO_KEY_CYCLE_NS     11680000
`define SMIO_KEY_SLOT_CYC     (`SMIO_KEY_CYCLE_NS / `SMIO_KEY_COMMONS / `SMIO_CLK_PERIOD_NS)
`define SMIO_LAMP_COMMONS     4
`define SMIO_LAMP_ON_NS       1460000
`define SMIO_LAMP_CYCLE_NS    5840000
`define SMIO_LAMP_SLOT_CYC    (`SMIO_LAMP_CYCLE_NS / `SMIO_LAMP_COMMONS / `SMIO_CLK_PERIOD_NS)
`define SMIO_FILT_NS          3000000
`define SMIO_FILT_CYC         ((`SMIO_FILT_NS + `SMIO_CLK_PERIOD_NS - 1) / `SMIO_CLK_PERIOD_NS)
`define SMIO_MAX_DELAY_NS     16000000

////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define SMIO_OFS_CTRL         8'h00
`define SMIO_OFS_STATUS       8'h04
`define SMIO_OFS_MASK         8'h08
`define SMIO_OFS_KEY_LO       8'h0c
`define SMIO_OFS_KEY_HI       8'h10
`define SMIO_OFS_LAMP_A       8'h14
`define SMIO_OFS_LAMP_B       8'h18
`define SMIO_OFS_DIN          8'h1c
`define SMIO_OFS_DOUT         8'h20
`define SMIO_OFS_STATION      8'h24
`define SMIO_OFS_ALARM        8'h28

////////////////////////////////////////////////////////////////////////
// Field positions and reset values.
`define SMIO_CTRL_KEY_EN      0
`define SMIO_CTRL_LAMP_EN     1
`define SMIO_CTRL_RESET       32'h0000_0003
`define SMIO_ST_KEY_CHG       0
`define SMIO_ST_DIN_CHG       1
`define SMIO_ST_LINK_ERR      2
`define SMIO_ST_CONFLICT      3
`define SMIO_ST_BITS          4
`define SMIO_UNIT_POINTS      32

`endif

// ===== design/smio_input_filter.v
// Purpose: Chatter filter for one plain digital input.
// Assumes: Input already passed a two-flop synchroniser.
// Notes:   Output follows the input only after it stays stable.
`timescale 1ns/10ps
module smio_input_filter #(
    parameter FILT_CYC = 120000
) (
    // Clock and reset.
    input  wire i_sys_clk,
    input  wire i_reset,
    // Level in and filtered level out.
    input  wire i_level,
    output wire o_level,
    output wire o_change
);
    localparam CW = $clog2(FILT_CYC + 1);

    reg [CW-1:0] cnt_q;      // Cycles the input has differed.
    reg          level_q;    // Accepted level.
    reg          change_q;   // One-cycle pulse on acceptance.

    ////////////////////////////////////////////////////////////////////
    // Count while the input differs; accept it at the full interval.
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            cnt_q    <= {CW{1'b0}};
            level_q  <= 1'b0;
            change_q <= 1'b0;
        end else begin
            change_q <= 1'b0;
            if (i_level == level_q) begin
                // A bounce back restarts the interval.
                cnt_q <= {CW{1'b0}}; // R14
            end else if (cnt_q == FILT_CYC[CW-1:0] - 1'b1) begin
                level_q  <= i_level; // R14 R13
                change_q <= 1'b1;
                cnt_q    <= {CW{1'b0}};
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign o_level  = level_q;
    assign o_change = change_q;
endmodule

// ===== verif/smio_scan_matrix_io_asserts.sv
// Purpose: Port checker for the scan matrix I/O unit.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into the top module.
`timescale 1ns/10ps
module smio_sva #(
    parameter KEY_SLOT_CYC  = 8,
    parameter LAMP_SLOT_CYC = 6
) (
    input wire       i_sys_clk,
    input wire       i_reset,
    input wire [7:0] o_key_matrix_common_lines_n,
    input wire [3:0] o_lamp_matrix_common_a,
    input wire [3:0] o_lamp_matrix_common_b,
    input wire [7:0] o_lamp_matrix_data_lines_a_n,
    input wire [2:0] i_station_link_error,
    input wire       o_first_station_alarm_led,
    input wire       o_second_station_alarm_led,
    input wire       o_third_station_alarm_led
);
    wire [7:0]   kc = o_key_matrix_common_lines_n;  // Key commons.
    wire [3:0]   la = o_lamp_matrix_common_a;       // Lamp commons.
    logic [31:0] kcnt_q;  // Cycles since key change.
    logic [31:0] lcnt_q;  // Cycles since lamp change.
    ////////////////////////////////////////////////////////////////////
    // Cycles each common pattern has stood.
    always @(posedge i_sys_clk) begin
        kcnt_q <= (i_reset || $changed(kc)) ? 0 : kcnt_q + 1;
        lcnt_q <= (i_reset || $changed(la)) ? 0 : lcnt_q + 1;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    a_key_onehot: assert property ($onehot0(~kc))
        else $error("key commons not one hot");
    a_key_slot: assert property (($changed(kc) && kc != 8'hff &&
        $past(kc) != 8'hff) |-> kcnt_q == KEY_SLOT_CYC - 1)
        else $error("key slot length");
    a_key_order: assert property (($changed(kc) && kc != 8'hff &&
        $past(kc) != 8'hff) |-> kc == {$past(kc[6:0]), $past(kc[7])})
        else $error("bad key order");
    a_lamp_banks: assert property ($onehot0(la) && la == o_lamp_matrix_common_b)
        else $error("lamp commons bad");
    a_lamp_slot: assert property (($changed(la) && la != 4'h0 &&
        $past(la) != 4'h0) |-> lcnt_q == LAMP_SLOT_CYC - 1)
        else $error("lamp slot length");
    a_lamp_order: assert property (($changed(la) && la != 4'h0 &&
        $past(la) != 4'h0) |-> la == {$past(la[2:0]), $past(la[3])})
        else $error("bad lamp order");
    a_lamp_dark: assert property (la == 4'h0 |->
        o_lamp_matrix_data_lines_a_n == 8'hff)
        else $error("lamp data with no common");
    a_alarm_follow: assert property (!$past(i_reset) |->
        {o_third_station_alarm_led, o_second_station_alarm_led,
         o_first_station_alarm_led} == $past(i_station_link_error))
        else $error("alarms not following errors");
endmodule
bind smio_scan_matrix_io smio_sva #(
    .KEY_SLOT_CYC (KEY_SLOT_CYC),
    .LAMP_SLOT_CYC(LAMP_SLOT_CYC)
) smio_sva_i (
    .i_sys_clk, .i_reset, .o_key_matrix_common_lines_n,
    .o_lamp_matrix_common_a, .o_lamp_matrix_common_b,
    .o_lamp_matrix_data_lines_a_n, .i_station_link_error,
    .o_first_station_alarm_led, .o_second_station_alarm_led,
    .o_third_station_alarm_led
);

// ===== verif/smio_panel_model.sv
// Purpose: Key matrix of the operation panel.
// Assumes: Diode per key, pull-ups on the data lines.
// Notes:   Bench holds keys for whole scan cycles.
`timescale 1ns/10ps
module smio_panel_model (
    input  wire [7:0]  i_common_n,  // Key commons, low = selected.
    input  wire [63:0] i_keys,      // Byte n = keys on common n.
    output logic [7:0] o_data_n     // Data lines, low = pressed.
);
    // A pressed key pulls its data line low while its common is low.
    always @* begin
        o_data_n = 8'hff;
        for (int r = 0; r < 8; r++) begin
            if (!i_common_n[r]) begin
                o_data_n = o_data_n & ~i_keys[8*r +: 8];
            end
        end
    end
endmodule

// ===== verif/test_smio_scan_matrix_io.sv
// Purpose: Self-checking bench for the scan matrix I/O unit.
// Assumes: Shortened slot and filter counts.
// Notes:   Registers are reached by APB tasks.
`timescale 1ns/10ps
`include "smio_consts.vh"
module test_smio_scan_matrix_io;
    localparam KS = 8;
    localparam FC = 5;
    logic        i_sys_clk = 1'b0;
    logic        i_reset   = 1'b1;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, irq, e;
    logic [7:0]  paddr = 8'h00, kc_n, kd_n, lda_n, ldb_n;
    logic [31:0] pwdata = 32'h0, pin = 32'h0, prdata, pout, rd;
    logic [3:0]  lca, lcb;
    logic [63:0] keys = 64'h0;  // Pressed keys.
    logic [2:0]  sw1 = 3'h0, sw2 = 3'h1, swp = 3'h2, lerr = 3'h0, alm;
    int          err_total = 0, total_checks = 0, n;
    always #12.5 i_sys_clk = ~i_sys_clk;
    smio_scan_matrix_io #(.KEY_SLOT_CYC(KS), .LAMP_SLOT_CYC(6),
        .FILT_CYC(FC)) smio_scan_matrix_io_i (
        .i_sys_clk, .i_reset, .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_key_matrix_common_lines_n(kc_n), .i_key_matrix_data_lines_n(kd_n),
        .o_lamp_matrix_common_a(lca), .o_lamp_matrix_common_b(lcb),
        .o_lamp_matrix_data_lines_a_n(lda_n),
        .o_lamp_matrix_data_lines_b_n(ldb_n),
        .i_plain_inputs(pin), .o_plain_outputs(pout),
        .i_first_scan_station_switch(sw1),
        .i_second_scan_station_switch(sw2), .i_plain_io_station_switch(swp),
        .i_station_link_error(lerr), .o_first_station_alarm_led(alm[0]),
        .o_second_station_alarm_led(alm[1]),
        .o_third_station_alarm_led(alm[2]), .o_irq(irq));
    smio_panel_model smio_panel_model_i (.i_common_n(kc_n), .i_keys(keys),
        .o_data_n(kd_n));
    ////////////////////////////////////////////////////////////////////
    // Prints counts and verdict, then stops.
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Compares and counts one value.
    task cmp(input string nm, input logic [31:0] x, g);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask
    // One APB transfer, held until pready is high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k = 0;
        @(posedge i_sys_clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_sys_clk);
        pen <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        e  = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (pready !== 1'b1) begin
            cmp("pready", 32'h1, {31'h0, pready});
            complete_run;
        end
    endtask
    // Waits c clock cycles.
    task cyc(input int c);
        repeat (c) @(posedge i_sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        cyc(2);
        i_reset <= 1'b0;
        apb(0, `SMIO_OFS_CTRL, 0);
        cmp("ctrl", `SMIO_CTRL_RESET, rd);
        apb(0, 8'h30, 0);
        cmp("unmapped err", 32'h1, {31'h0, e});
        apb(1, `SMIO_OFS_DOUT, 32'ha5a5_0f0f);
        cyc(1);
        cmp("outputs", 32'ha5a5_0f0f, pout);
        apb(1, `SMIO_OFS_KEY_LO, 32'hffff_ffff);
        apb(0, `SMIO_OFS_KEY_LO, 0);
        cmp("key ro", 32'h0, rd);
        $display("registers done");
        apb(0, `SMIO_OFS_STATION, 0);
        cmp("station", 32'h5f40_0088, rd);
        sw2 <= 3'h0;
        cyc(4);
        apb(0, `SMIO_OFS_STATION, 0);
        cmp("collision", 32'h5f40_0280, rd);
        sw2 <= 3'h1;
        $display("stations done");
        keys <= 64'h0102_0408_1020_4080;
        cyc(2 * 8 * KS + 10);
        apb(0, `SMIO_OFS_KEY_LO, 0);
        cmp("keys low", 32'h1020_4080, rd);
        apb(0, `SMIO_OFS_KEY_HI, 0);
        cmp("keys high", 32'h0102_0408, rd);
        apb(1, `SMIO_OFS_MASK, 32'h1);
        cyc(4);
        cmp("irq set", 32'h1, {31'h0, irq});
        apb(1, `SMIO_OFS_STATUS, 32'h1);
        cyc(4);
        cmp("irq clear", 32'h0, {31'h0, irq});
        apb(1, `SMIO_OFS_CTRL, 32'h2);
        keys <= 64'h0;
        cyc(3 * 8 * KS);
        cmp("key idle", 32'hff, {24'h0, kc_n});
        apb(0, `SMIO_OFS_KEY_LO, 0);
        cmp("key held", 32'h1020_4080, rd);
        $display("keys done");
        apb(1, `SMIO_OFS_LAMP_A, 32'h8421_1248);
        apb(1, `SMIO_OFS_LAMP_B, 32'h0f0f_f0f0);
        cyc(2);
        for (int i = 0; i < 4; i++) begin
            for (n = 0; n < 60 && lca !== 4'h1 << i; n++) cyc(1);
            cmp("lamp common", 32'h1 << i, {28'h0, lcb});
            cmp("lamp a", ~(32'h8421_1248 >> 8*i) & 32'hff, lda_n);
            cmp("lamp b", ~(32'h0f0f_f0f0 >> 8*i) & 32'hff, ldb_n);
        end
        apb(1, `SMIO_OFS_CTRL, 32'h1);
        cyc(3);
        cmp("lamp off", 32'hffff, {12'h0, lca, lda_n, ldb_n});
        $display("lamps done");
        pin <= 32'h8000_0001;
        cyc(FC + 10);
        pin[4] <= 1'b1;
        cyc(2);
        pin[4] <= 1'b0;
        cyc(FC + 10);
        apb(0, `SMIO_OFS_DIN, 0);
        cmp("inputs", 32'h8000_0001, rd);
        apb(0, `SMIO_OFS_STATUS, 0);
        cmp("input change", 32'h2, rd & 32'h2);
        $display("inputs done");
        lerr <= 3'b101;
        cyc(2);
        cmp("alarm on", 32'h5, {29'h0, alm});
        lerr <= 3'b010;
        cyc(2);
        apb(0, `SMIO_OFS_ALARM, 0);
        cmp("alarm reg", 32'h2, rd);
        cmp("alarm swap", 32'h2, {29'h0, alm});
        $display("alarms done");
        complete_run;
    end
endmodule
